/* File: eqlt_pkg.sv */
// Constants and types shared by the equalizer and loop-through configuration block.
`default_nettype none
package eqlt_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] EQ_OVERRIDE_ADDR = 8'h44;
  localparam logic [7:0] AEQ_FLOOR_ADDR   = 8'h45;
  localparam logic [7:0] PORT_TARGET_ADDR = 8'h70;
  localparam logic [7:0] MIRROR_SEL_A_ADDR = 8'h52;
  localparam logic [7:0] DRIVER_EN_ADDR   = 8'h56;
  localparam logic [7:0] MIRROR_SEL_B_ADDR = 8'h57;
  localparam logic [7:0] TX_SLEEP_ADDR    = 8'h63;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] EQ_OVERRIDE_RST  = 8'h60;
  localparam logic [7:0] AEQ_FLOOR_RST    = 8'h88;
  localparam logic [7:0] PORT_TARGET_RST  = 8'h00;
  localparam logic [7:0] MIRROR_SEL_A_RST = 8'h00;
  localparam logic [7:0] DRIVER_EN_RST    = 8'h00;
  localparam logic [7:0] MIRROR_SEL_B_RST = 8'h00;
  localparam logic [7:0] TX_SLEEP_RST     = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BYPASS_BIT      = 0;
  localparam int LOW_STAGE_LSB   = 1;
  localparam int HIGH_STAGE_LSB  = 5;
  localparam int FLOOR_LSB       = 0;
  localparam int TARGET_BIT      = 0;
  localparam int MIRROR_BIT_POS  = 7;
  localparam int DRIVER_ON_BIT   = 3;
  localparam int MIRROR_FIELD_LSB = 1;
  localparam int SLEEP_BIT       = 0;

  // ****************************************************************
  // Port field encodings
  // ****************************************************************
  localparam logic [1:0] FIELD_FIRST  = 2'h1;
  localparam logic [1:0] FIELD_SECOND = 2'h2;

  // ****************************************************************
  // Register port request
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : eqlt_pkg

`default_nettype wire

/* File: eq_and_loopthrough_config.sv */
// Equalizer override, adaptive floor and loop-through output configuration registers.
//
// Behaviour
// R01: Hold 3-bit lower-stage manual value; it drives setting bits 2:0 only when bypassed.
// R02: Hold 3-bit upper-stage manual value; it drives setting bits 5:3 only when bypassed.
// R03: Override register bit 0 chooses adaptive equalization or manual stage values.
// R04: Bypass bit 1 applies manual values; 0 keeps adaptation running.
// R05: Adaptation starts from a 4-bit programmable floor, reset value 8.
// R06: With second-port target set, floor writes go to the second port's equalizer.
// R07: Select-A bit 7 mirrors first port when 0, second port when 1.
// R08: Select-B field bits 2:1 mirror first port on 01, second on 10.
// R09: Software keeps the select bit and the select field naming the same port.
// R10: Loop-through driver runs only while enable bit 3 is set; off at reset.
// R11: Transmitter control bit 0 powers the transmitter down; reset is powered up.
// R12: Software powers the transmitter down before enabling the pattern generator.
`timescale 1ns/1ns
`default_nettype none

module eq_and_loopthrough_config #(
  parameter int DATA_W = 10
) (
  input  wire logic              CLK_SYS,
  input  wire logic              NRST,
  input  wire logic [7:0]        ADDR,
  input  wire logic [7:0]        WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [7:0]        RDATA,
  input  wire logic [5:0]        ADAPT_EQ_VALUE,
  input  wire logic [DATA_W-1:0] FIRST_LINK_INPUT,
  input  wire logic [DATA_W-1:0] SECOND_LINK_INPUT,
  output logic      [5:0]        EQ_SETTING,
  output logic                   EQ_ADAPT_ENABLE,
  output logic      [3:0]        EQ_SEARCH_FLOOR_FIRST,
  output logic      [3:0]        EQ_SEARCH_FLOOR_SECOND,
  output logic      [DATA_W-1:0] LOOPTHROUGH_OUTPUT,
  output logic                   MIRROR_DRIVER_ON,
  output logic                   MIRROR_TX_SLEEP,
  output logic                   MIRROR_SEL_MISMATCH
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************

  // Returns 1 when the 2-bit field names the second input port.
  function automatic logic field_is_second(input logic [1:0] field);
    field_is_second = (field == eqlt_pkg::FIELD_SECOND);
  endfunction : field_is_second

  // Returns 1 when the 2-bit field names a valid port matching the bit.
  function automatic logic field_matches(input logic [1:0] field, input logic bit_sel);
    field_matches = bit_sel ? (field == eqlt_pkg::FIELD_SECOND)
                            : (field == eqlt_pkg::FIELD_FIRST);
  endfunction : field_matches

  // Returns 1 for a write strobe aimed at the given offset.
  function automatic logic wr_hit(input eqlt_pkg::reg_req_t r, input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction : wr_hit

  // ****************************************************************
  // Request capture
  // ****************************************************************
  eqlt_pkg::reg_req_t req;

  assign req = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

  logic [7:0] eq_override_q;
  logic [7:0] port_target_q;
  logic [7:0] sel_a_q;
  logic [7:0] driver_en_q;
  logic [7:0] sel_b_q;
  logic [7:0] tx_sleep_q;
  logic [7:0] floor_q [2];
  logic       second_sel;

  assign second_sel = port_target_q[eqlt_pkg::TARGET_BIT];

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      eq_override_q <= eqlt_pkg::EQ_OVERRIDE_RST;
    end else if (wr_hit(req, eqlt_pkg::EQ_OVERRIDE_ADDR)) begin
      eq_override_q <= req.wdata; // see R01 R02 R03
    end
  end

  // The target bit decides which port's floor the shared offset reaches.
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      port_target_q <= eqlt_pkg::PORT_TARGET_RST;
    end else if (wr_hit(req, eqlt_pkg::PORT_TARGET_ADDR)) begin
      port_target_q <= req.wdata; // see R06
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      sel_a_q <= eqlt_pkg::MIRROR_SEL_A_RST;
    end else if (wr_hit(req, eqlt_pkg::MIRROR_SEL_A_ADDR)) begin
      sel_a_q <= req.wdata; // see R07
    end
  end

  // The driver stays off from reset until software turns it on.
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      driver_en_q <= eqlt_pkg::DRIVER_EN_RST;
    end else if (wr_hit(req, eqlt_pkg::DRIVER_EN_ADDR)) begin
      driver_en_q <= req.wdata; // see R10
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      sel_b_q <= eqlt_pkg::MIRROR_SEL_B_RST;
    end else if (wr_hit(req, eqlt_pkg::MIRROR_SEL_B_ADDR)) begin
      sel_b_q <= req.wdata; // see R08
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      tx_sleep_q <= eqlt_pkg::TX_SLEEP_RST;
    end else if (wr_hit(req, eqlt_pkg::TX_SLEEP_ADDR)) begin
      tx_sleep_q <= req.wdata; // see R11
    end
  end

  // ****************************************************************
  // Per-port adaptive floor registers
  // ****************************************************************

  // The floor offset is shared; the target bit steers writes to one port.
  for (genvar p = 0; p < 2; p++) begin : g_floor
    always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
        floor_q[p] <= eqlt_pkg::AEQ_FLOOR_RST; // see R05
      end else if (req.wr && req.addr == eqlt_pkg::AEQ_FLOOR_ADDR
                   && second_sel == (p == 1)) begin
        floor_q[p] <= req.wdata; // see R06
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************

  // Data stand only in the cycle after the read strobe; other cycles read zero.
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    if (req.rd) begin
      case (req.addr)
        eqlt_pkg::EQ_OVERRIDE_ADDR:  rdata_d = eq_override_q;
        eqlt_pkg::AEQ_FLOOR_ADDR:    rdata_d = floor_q[second_sel]; // see R06
        eqlt_pkg::PORT_TARGET_ADDR:  rdata_d = port_target_q;
        eqlt_pkg::MIRROR_SEL_A_ADDR: rdata_d = sel_a_q;
        eqlt_pkg::DRIVER_EN_ADDR:    rdata_d = driver_en_q;
        eqlt_pkg::MIRROR_SEL_B_ADDR: rdata_d = sel_b_q;
        eqlt_pkg::TX_SLEEP_ADDR:     rdata_d = tx_sleep_q;
        default:                     rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= rdata_d;
    end
  end

  // ****************************************************************
  // Equalizer control
  // ****************************************************************
  logic bypass;

  assign bypass = eq_override_q[eqlt_pkg::BYPASS_BIT];

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      EQ_ADAPT_ENABLE <= 1'b0;
    end else begin
      EQ_ADAPT_ENABLE <= !bypass; // see R03 R04
    end
  end

  // Manual stage values replace the adaptive loop's value only while bypassed.
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      EQ_SETTING <= 6'h00;
    end else if (bypass) begin
      EQ_SETTING <= {eq_override_q[eqlt_pkg::HIGH_STAGE_LSB +: 3],  // see R02
                     eq_override_q[eqlt_pkg::LOW_STAGE_LSB +: 3]};  // see R01
    end else begin
      EQ_SETTING <= ADAPT_EQ_VALUE; // see R04
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      EQ_SEARCH_FLOOR_FIRST <= 4'h0;
    end else begin
      EQ_SEARCH_FLOOR_FIRST <= floor_q[0][eqlt_pkg::FLOOR_LSB +: 4]; // see R05
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      EQ_SEARCH_FLOOR_SECOND <= 4'h0;
    end else begin
      EQ_SEARCH_FLOOR_SECOND <= floor_q[1][eqlt_pkg::FLOOR_LSB +: 4]; // see R05
    end
  end

  // ****************************************************************
  // Loop-through output path
  // ****************************************************************
  logic       mirror_bit;
  logic [1:0] mirror_field;
  logic       driver_on;
  logic       tx_sleep;

  assign mirror_bit   = sel_a_q[eqlt_pkg::MIRROR_BIT_POS];
  assign mirror_field = sel_b_q[eqlt_pkg::MIRROR_FIELD_LSB +: 2];
  assign driver_on    = driver_en_q[eqlt_pkg::DRIVER_ON_BIT];
  assign tx_sleep     = tx_sleep_q[eqlt_pkg::SLEEP_BIT];

  logic [DATA_W-1:0] mirror_d;

  // The port bit steers the mux; the field only has to agree with it.
  always_comb begin
    mirror_d = '0;
    if (driver_on && !tx_sleep) begin // see R10 R11
      mirror_d = mirror_bit ? SECOND_LINK_INPUT : FIRST_LINK_INPUT; // see R07
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      LOOPTHROUGH_OUTPUT <= '0;
    end else begin
      LOOPTHROUGH_OUTPUT <= mirror_d;
    end
  end

  // ****************************************************************
  // Loop-through status
  // ****************************************************************
  logic mismatch_d;

  // Software must keep both selectors on one port; a disagreement is flagged, not mended.
  assign mismatch_d = !field_matches(mirror_field, mirror_bit)
                      || (field_is_second(mirror_field) != mirror_bit); // see R08 R09

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      MIRROR_DRIVER_ON <= 1'b0;
    end else begin
      MIRROR_DRIVER_ON <= driver_on; // see R10
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      MIRROR_TX_SLEEP <= 1'b0;
    end else begin
      MIRROR_TX_SLEEP <= tx_sleep; // see R11
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      MIRROR_SEL_MISMATCH <= 1'b0;
    end else begin
      MIRROR_SEL_MISMATCH <= mismatch_d; // see R08 R09
    end
  end

endmodule : eq_and_loopthrough_config

`default_nettype wire

/* File: eqlt_monitor.sv */
// Concurrent checks on the ports of the equalizer and loop-through configuration block.
`timescale 1ns/1ns
`default_nettype none
module eqlt_monitor #(
  parameter int DATA_W = 10
) (
  input wire logic              CLK_SYS,
  input wire logic              NRST,
  input wire logic [7:0]        ADDR,
  input wire logic [7:0]        WDATA,
  input wire logic              WR,
  input wire logic [5:0]        ADAPT_EQ_VALUE,
  input wire logic [DATA_W-1:0] FIRST_LINK_INPUT,
  input wire logic [DATA_W-1:0] SECOND_LINK_INPUT,
  input wire logic [5:0]        EQ_SETTING,
  input wire logic              EQ_ADAPT_ENABLE,
  input wire logic [3:0]        EQ_SEARCH_FLOOR_FIRST,
  input wire logic [3:0]        EQ_SEARCH_FLOOR_SECOND,
  input wire logic [DATA_W-1:0] LOOPTHROUGH_OUTPUT,
  input wire logic              MIRROR_DRIVER_ON,
  input wire logic              MIRROR_TX_SLEEP
);
  logic tgt_q;
  logic sel_q;
  // Shadows of the port target bit and the mirror select bit.
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) tgt_q <= 1'b0;
    else if (WR && ADDR == 8'h70) tgt_q <= WDATA[0];
  end
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) sel_q <= 1'b0;
    else if (WR && ADDR == 8'h52) sel_q <= WDATA[7];
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  property p_adapt_en;
    WR && ADDR == 8'h44 |-> ##2 EQ_ADAPT_ENABLE == !$past(WDATA[0], 2);
  endproperty
  a_adapt_en: assert property (p_adapt_en) else $error("adapt enable wrong");
  property p_manual;
    WR && ADDR == 8'h44 && WDATA[0] |-> ##2 EQ_SETTING == {$past(WDATA[7:5], 2), $past(WDATA[3:1], 2)};
  endproperty
  a_manual: assert property (p_manual) else $error("manual setting wrong");
  property p_adapt_val; EQ_ADAPT_ENABLE |-> EQ_SETTING == $past(ADAPT_EQ_VALUE); endproperty
  a_adapt_val: assert property (p_adapt_val) else $error("adaptive setting wrong");
  property p_floor;
    WR && ADDR == 8'h45 |-> ##2 ($past(tgt_q, 2) ? EQ_SEARCH_FLOOR_SECOND : EQ_SEARCH_FLOOR_FIRST)
      == $past(WDATA[3:0], 2);
  endproperty
  a_floor: assert property (p_floor) else $error("floor wrong");
  property p_mirror;
    MIRROR_DRIVER_ON && !MIRROR_TX_SLEEP |-> LOOPTHROUGH_OUTPUT ==
      ($past(sel_q) ? $past(SECOND_LINK_INPUT) : $past(FIRST_LINK_INPUT));
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirrored data wrong");
  property p_quiet; !MIRROR_DRIVER_ON || MIRROR_TX_SLEEP |-> LOOPTHROUGH_OUTPUT == '0; endproperty
  a_quiet: assert property (p_quiet) else $error("output not quiet");
  property p_drv; WR && ADDR == 8'h56 |-> ##2 MIRROR_DRIVER_ON == $past(WDATA[3], 2); endproperty
  a_drv: assert property (p_drv) else $error("driver enable wrong");
  property p_sleep;
    WR && ADDR == 8'h63 |-> ##1 $stable(MIRROR_TX_SLEEP)
      ##1 MIRROR_TX_SLEEP == $past(WDATA[0], 2);
  endproperty
  a_sleep: assert property (p_sleep) else $error("powerdown wrong");
  c_bypass: cover property (WR && ADDR == 8'h44 && WDATA[0]);
  c_second: cover property (tgt_q && WR && ADDR == 8'h45);
  c_mirror: cover property (MIRROR_DRIVER_ON && !MIRROR_TX_SLEEP);
endmodule : eqlt_monitor
bind eq_and_loopthrough_config eqlt_monitor #(.DATA_W(DATA_W)) i_mon (.*);
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the equalizer and loop-through configuration block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic       clk_sys = 1'b0;
  logic       nrst    = 1'b0;
  logic [7:0] addr    = 8'h00;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic [5:0] adapt   = 6'h2A;
  logic [9:0] in_a    = 10'h155;
  logic [9:0] in_b    = 10'h2AA;
  logic [7:0] rdata;
  logic [5:0] eq_set;
  logic       eq_en, drv_on, sleep, mism;
  logic [3:0] fl_a, fl_b;
  logic [9:0] lt_out;
  int         miscompares = 0;
  int         compares = 0;
  int         cycles = 0;
  initial forever #20 clk_sys = ~clk_sys;
  eq_and_loopthrough_config #(.DATA_W(10)) i_dut (.CLK_SYS(clk_sys), .NRST(nrst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .ADAPT_EQ_VALUE(adapt),
    .FIRST_LINK_INPUT(in_a), .SECOND_LINK_INPUT(in_b), .EQ_SETTING(eq_set),
    .EQ_ADAPT_ENABLE(eq_en), .EQ_SEARCH_FLOOR_FIRST(fl_a), .EQ_SEARCH_FLOOR_SECOND(fl_b),
    .LOOPTHROUGH_OUTPUT(lt_out), .MIRROR_DRIVER_ON(drv_on), .MIRROR_TX_SLEEP(sleep),
    .MIRROR_SEL_MISMATCH(mism));
  task automatic report_and_stop;
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // A write lands at the sampling edge; derived outputs settle one cycle later.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    check("rdata", 10'(exp), 10'(rdata));
  endtask : rd_reg
  task automatic t_regs;
    logic [7:0] a [8] = '{8'h44, 8'h45, 8'h70, 8'h52, 8'h56, 8'h57, 8'h63, 8'h99};
    logic [7:0] v [8] = '{8'h60, 8'h88, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) rd_reg(a[i], v[i]);
    check("adapt_en", 10'h001, 10'(eq_en));
    check("floor_a", 10'h008, 10'(fl_a));
    check("floor_b", 10'h008, 10'(fl_b));
    check("tx_sleep", 10'h000, 10'(sleep));
    wr_reg(8'h99, 8'hFF);
    rd_reg(8'h99, 8'h00);
  endtask : t_regs
  task automatic t_eq;
    check("eq_adapt", 10'h02A, 10'(eq_set));
    wr_reg(8'h44, 8'hA7);
    check("eq_manual", 10'h02B, 10'(eq_set));
    check("adapt_off", 10'h000, 10'(eq_en));
    @(posedge clk_sys);
    adapt <= 6'h11;
    repeat (2) @(negedge clk_sys);
    check("eq_held", 10'h02B, 10'(eq_set));
    wr_reg(8'h44, 8'hA6);
    check("eq_resume", 10'h011, 10'(eq_set));
  endtask : t_eq
  task automatic t_floor;
    wr_reg(8'h45, 8'h03);
    check("floor_a", 10'h003, 10'(fl_a));
    wr_reg(8'h70, 8'h01);
    wr_reg(8'h45, 8'hFC);
    check("floor_b", 10'h00C, 10'(fl_b));
    check("floor_a", 10'h003, 10'(fl_a));
    rd_reg(8'h45, 8'hFC);
    wr_reg(8'h70, 8'h00);
    rd_reg(8'h45, 8'h03);
  endtask : t_floor
  task automatic t_loop;
    wr_reg(8'h52, 8'h80);
    check("lt_off", 10'h000, lt_out);
    wr_reg(8'h56, 8'h08);
    check("drv_on", 10'h001, 10'(drv_on));
    check("lt_second", in_b, lt_out);
    wr_reg(8'h57, 8'h04);
    check("mismatch", 10'h000, 10'(mism));
    wr_reg(8'h52, 8'h00);
    check("lt_first", in_a, lt_out);
    check("mismatch", 10'h001, 10'(mism));
    wr_reg(8'h57, 8'h02);
    check("mismatch", 10'h000, 10'(mism));
    wr_reg(8'h63, 8'h01);
    check("tx_sleep", 10'h001, 10'(sleep));
    check("lt_sleep", 10'h000, lt_out);
  endtask : t_loop
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_eq();
    t_floor();
    t_loop();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
